// file: include/dsw_pkg.sv
// Package with status word layout, register numbers and scaling constants.
package dsw_pkg;

    // ************************************************************
    // Status word bit positions
    // ************************************************************
    localparam int unsigned BIT_CTRL_READY  = 0;
    localparam int unsigned BIT_DRV_READY   = 1;
    localparam int unsigned BIT_ENABLE      = 2;
    localparam int unsigned BIT_TRIP        = 3;
    localparam int unsigned BIT_ERROR       = 4;
    localparam int unsigned BIT_RESERVED    = 5;
    localparam int unsigned BIT_TRIPLOCK    = 6;
    localparam int unsigned BIT_WARNING     = 7;
    localparam int unsigned BIT_AT_REF      = 8;
    localparam int unsigned BIT_BUS_CTRL    = 9;
    localparam int unsigned BIT_FREQ_OK     = 10;
    localparam int unsigned BIT_IN_OPER     = 11;
    localparam int unsigned BIT_AUTO_STOP   = 12;
    localparam int unsigned BIT_VOLT_EXC    = 13;
    localparam int unsigned BIT_CURR_EXC    = 14;
    localparam int unsigned BIT_TIMER_EXC   = 15;

    // ************************************************************
    // Register numbers, widths and reset values
    // ************************************************************
    localparam logic [15:0] REG_STATUS_HIGH = 16'hc418; // Holding register 50200.
    localparam logic [15:0] REG_STATUS_LOW  = 16'h0b5e; // Holding register 02910.
    localparam logic [15:0] REG_VALUE_HIGH  = 16'hc422; // Holding register 50210.
    localparam logic [15:0] REG_VALUE_LOW   = 16'h0b5f; // Holding register 02911.
    localparam int unsigned WORD_W          = 16;
    localparam logic [15:0] STATUS_RESET    = 16'h0000;
    localparam logic [15:0] READ_MISS_VALUE = 16'h0000;

    // ************************************************************
    // Protocol selection and relative scaling
    // ************************************************************
    localparam logic [7:0]  PROTO_NATIVE    = 8'h00;
    localparam logic [15:0] SCALE_FULL      = 16'h4000; // Integer 16384 is 100 percent.
    localparam int unsigned SCALE_SHIFT     = 14;
    localparam logic [15:0] TIMER_FULL      = 16'h4000;

endpackage : dsw_pkg

// file: src/dsw_freq_scale.sv
// Scaling of actual output frequency into the signed relative bus format.
`timescale 1ns/1ps
module dsw_freq_scale #(
    parameter int unsigned FREQ_W = 16
) (
    // Clock and reset
    input  wire logic                     i_ref_clk,
    input  wire logic                     i_sys_rst,
    // Frequency in, relative value out
    input  wire logic signed [FREQ_W-1:0] i_freq,
    input  wire logic        [FREQ_W-1:0] i_freq_max,
    output logic signed [15:0]            o_rel
);
    // Widths below 2 or above 24 are rejected; the FREQ_W+16 bit product cannot overflow.
    if (FREQ_W < 2 || FREQ_W > 24) begin : g_freq_w_check
        $error("FREQ_W out of range");
    end

    logic signed [15:0]          rel_r;
    logic signed [15:0]          rel_nxt;
    logic signed [FREQ_W+15:0]   prod;
    logic signed [FREQ_W+15:0]   quot;

    // A zero full-scale frequency would divide by zero, so it reports zero instead.
    always_comb begin
        prod = (FREQ_W+16)'(i_freq) <<< dsw_pkg::SCALE_SHIFT;
        quot = '0;
        if (i_freq_max != '0) begin
            quot = prod / $signed((FREQ_W+16)'({1'b0, i_freq_max}));
        end
        rel_nxt = quot[15:0]; // [RULE19] [RULE18]
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            rel_r <= '0;
        end else begin
            rel_r <= rel_nxt;
        end
    end

    assign o_rel = rel_r;

endmodule : dsw_freq_scale

// file: src/dsw_reg_read.sv
// Read decode for the status word and main value holding registers.
`timescale 1ns/1ps
module dsw_reg_read (
    // Clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_sys_rst,
    // Read request
    input  wire logic        i_rd_req,
    input  wire logic [15:0] i_rd_addr,
    input  wire logic [15:0] i_status,
    input  wire logic [15:0] i_value,
    // Read answer
    output logic             o_rd_valid,
    output logic             o_rd_err,
    output logic [15:0]      o_rd_data
);
    logic        valid_r, valid_nxt;
    logic        err_r, err_nxt;
    logic [15:0] data_r, data_nxt;

    always_comb begin
        valid_nxt = i_rd_req;
        err_nxt   = 1'b0;
        data_nxt  = data_r;
        if (i_rd_req) begin
            case (i_rd_addr)
                dsw_pkg::REG_STATUS_HIGH, dsw_pkg::REG_STATUS_LOW: begin
                    data_nxt = i_status; // [RULE20]
                end
                dsw_pkg::REG_VALUE_HIGH, dsw_pkg::REG_VALUE_LOW: begin
                    data_nxt = i_value;
                end
                default: begin
                    data_nxt = dsw_pkg::READ_MISS_VALUE;
                    err_nxt  = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            valid_r <= 1'b0;
            err_r   <= 1'b0;
            data_r  <= '0;
        end else begin
            valid_r <= valid_nxt;
            err_r   <= err_nxt;
            data_r  <= data_nxt;
        end
    end

    assign o_rd_valid = valid_r;
    assign o_rd_err   = err_r;
    assign o_rd_data  = data_r;

endmodule : dsw_reg_read

// file: src/dsw_status_word.sv
// Status word assembly and register read port of the drive.
// Function
// (RULE1) Layout applies only under native profile selection.
// (RULE2) Bit 0: control ready, cleared on trip.
// (RULE3) Bit 1: ready while coast command active.
// (RULE4) Bit 2: zero while coasting, else enabled; the code also clears it on trip or trip lock.
// (RULE5) Bit 3: tripped, reset needed.
// (RULE6) Bit 4: error without trip.
// (RULE7) Bit 5: reserved, reads zero.
// (RULE8) Bit 6: tripped and locked.
// (RULE9) Bit 7: any warning present.
// (RULE10) Bit 8: speed equals reference.
// (RULE11) Bit 9: serial link may control.
// (RULE12) Bit 10: frequency inside speed limits.
// (RULE13) Bit 11: start active without coast.
// (RULE14) Bit 12: overtemperature halt with auto restart.
// (RULE15) Bit 13: DC link voltage out of range.
// (RULE16) Bit 14: current above configured limit.
// (RULE17) Bit 15: a thermal timer over full scale.
// (RULE18) Reference: signed 16-bit, 16384 equals 100 percent.
// (RULE19) Actual frequency uses same scaling.
// (RULE20) Status readable at both holding registers.
// (RULE21) All bits refreshed together each cycle.
`timescale 1ns/1ps
module dsw_status_word #(
    parameter int unsigned FREQ_W = 16
) (
    // Clock and reset
    input  wire logic                     i_ref_clk,
    input  wire logic                     i_sys_rst,
    // Protocol selection
    input  wire logic [7:0]               i_protocol_sel,
    // Drive condition inputs
    input  wire logic                     i_ctrl_ready,
    input  wire logic                     i_tripped,
    input  wire logic                     i_trip_locked,
    input  wire logic                     i_coast_cmd,
    input  wire logic                     i_start_cmd,
    input  wire logic                     i_error_no_trip,
    input  wire logic                     i_warning,
    input  wire logic                     i_local_off_key,
    input  wire logic                     i_ref_site_local,
    input  wire logic                     i_overtemp_halt,
    input  wire logic                     i_dc_low,
    input  wire logic                     i_dc_high,
    input  wire logic [15:0]              i_motor_current,
    input  wire logic [15:0]              i_current_limit,
    input  wire logic [15:0]              i_motor_timer,
    input  wire logic [15:0]              i_drive_timer,
    // Speed and frequency
    input  wire logic signed [15:0]       i_speed_ref,
    input  wire logic signed [FREQ_W-1:0] i_out_freq,
    input  wire logic        [FREQ_W-1:0] i_freq_max,
    input  wire logic        [FREQ_W-1:0] i_freq_low_lim,
    input  wire logic        [FREQ_W-1:0] i_freq_high_lim,
    // Register read port
    input  wire logic                     i_rd_req,
    input  wire logic [15:0]              i_rd_addr,
    output logic                          o_rd_valid,
    output logic                          o_rd_err,
    output logic [15:0]                   o_rd_data,
    // Direct views
    output logic [15:0]                   o_drive_status_word,
    output logic signed [15:0]            o_actual_output_frequency_value
);
    if (FREQ_W < 2 || FREQ_W > 24) begin : g_freq_w_check
        $error("FREQ_W out of range");
    end

    // ************************************************************
    // Relative frequency value
    // ************************************************************
    logic signed [15:0] rel_freq;
    logic        [FREQ_W-1:0] freq_mag;

    dsw_freq_scale #(.FREQ_W(FREQ_W)) u_scale (
        .i_ref_clk  (i_ref_clk),
        .i_sys_rst  (i_sys_rst),
        .i_freq     (i_out_freq),
        .i_freq_max (i_freq_max),
        .o_rel      (rel_freq)
    );

    assign o_actual_output_frequency_value = rel_freq;

    // ************************************************************
    // Status word assembly
    // ************************************************************
    logic [15:0] status_r;
    logic [15:0] status_nxt;
    logic        fault;

    // Limits compare on magnitude so reverse running is treated alike.
    always_comb begin
        freq_mag   = i_out_freq[FREQ_W-1] ? FREQ_W'(-i_out_freq) : FREQ_W'(i_out_freq);
        fault      = i_tripped | i_trip_locked;
        status_nxt = dsw_pkg::STATUS_RESET;
        if (i_protocol_sel == dsw_pkg::PROTO_NATIVE) begin // [RULE1]
            status_nxt[dsw_pkg::BIT_CTRL_READY] = i_ctrl_ready & ~fault;        // [RULE2]
            status_nxt[dsw_pkg::BIT_DRV_READY]  = i_ctrl_ready & ~fault
                                                  & i_coast_cmd;                // [RULE3]
            status_nxt[dsw_pkg::BIT_ENABLE]     = ~i_coast_cmd & ~fault;        // [RULE4]
            status_nxt[dsw_pkg::BIT_TRIP]       = i_tripped;                    // [RULE5]
            status_nxt[dsw_pkg::BIT_ERROR]      = i_error_no_trip;              // [RULE6]
            status_nxt[dsw_pkg::BIT_RESERVED]   = 1'b0;                         // [RULE7]
            status_nxt[dsw_pkg::BIT_TRIPLOCK]   = i_trip_locked;                // [RULE8]
            status_nxt[dsw_pkg::BIT_WARNING]    = i_warning;                    // [RULE9]
            status_nxt[dsw_pkg::BIT_AT_REF]     = (rel_freq == i_speed_ref);    // [RULE10]
            status_nxt[dsw_pkg::BIT_BUS_CTRL]   = ~i_local_off_key
                                                  & ~i_ref_site_local;          // [RULE11]
            status_nxt[dsw_pkg::BIT_FREQ_OK]    = (freq_mag > i_freq_low_lim)
                                                  & (freq_mag < i_freq_high_lim); // [RULE12]
            status_nxt[dsw_pkg::BIT_IN_OPER]    = i_start_cmd & ~i_coast_cmd
                                                  & ~fault;                     // [RULE13]
            status_nxt[dsw_pkg::BIT_AUTO_STOP]  = i_overtemp_halt & ~fault;     // [RULE14]
            status_nxt[dsw_pkg::BIT_VOLT_EXC]   = i_dc_low | i_dc_high;         // [RULE15]
            status_nxt[dsw_pkg::BIT_CURR_EXC]   = i_motor_current > i_current_limit; // [RULE16]
            status_nxt[dsw_pkg::BIT_TIMER_EXC]  = (i_motor_timer > dsw_pkg::TIMER_FULL)
                                                  | (i_drive_timer > dsw_pkg::TIMER_FULL); // [RULE17]
        end
    end

    // The whole word is registered at once so a read never mixes two cycles.
    always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            status_r <= dsw_pkg::STATUS_RESET;
        end else begin
            status_r <= status_nxt; // [RULE21]
        end
    end

    assign o_drive_status_word = status_r;

    // ************************************************************
    // Register read
    // ************************************************************
    dsw_reg_read u_read (
        .i_ref_clk  (i_ref_clk),
        .i_sys_rst  (i_sys_rst),
        .i_rd_req   (i_rd_req),
        .i_rd_addr  (i_rd_addr),
        .i_status   (status_r),
        .i_value    (rel_freq),
        .o_rd_valid (o_rd_valid),
        .o_rd_err   (o_rd_err),
        .o_rd_data  (o_rd_data)
    );

    // ************************************************************
    // Checks
    // ************************************************************
    a_reserved_zero: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        !status_r[dsw_pkg::BIT_RESERVED]) else $error("reserved bit set"); // [RULE7]

    a_trip_follows: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_tripped && i_protocol_sel == dsw_pkg::PROTO_NATIVE) |=>
        (status_r[dsw_pkg::BIT_TRIP] && !status_r[dsw_pkg::BIT_CTRL_READY]))
        else $error("trip not reported"); // [RULE5]

    a_profile_gate: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_protocol_sel != dsw_pkg::PROTO_NATIVE) |=> (status_r == dsw_pkg::STATUS_RESET))
        else $error("word active outside native profile"); // [RULE1]

    a_coast_enable: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_coast_cmd && i_protocol_sel == dsw_pkg::PROTO_NATIVE) |=>
        (!status_r[dsw_pkg::BIT_ENABLE] && !status_r[dsw_pkg::BIT_IN_OPER]))
        else $error("enable set while coasting"); // [RULE4]

    a_bus_local: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_ref_site_local || i_local_off_key) |=> !status_r[dsw_pkg::BIT_BUS_CTRL])
        else $error("bus control while local"); // [RULE11]

    a_volt_flag: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_dc_high && i_protocol_sel == dsw_pkg::PROTO_NATIVE) |=>
        status_r[dsw_pkg::BIT_VOLT_EXC]) else $error("voltage flag missing"); // [RULE15]

    a_current_flag: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_motor_current <= i_current_limit) |=> !status_r[dsw_pkg::BIT_CURR_EXC])
        else $error("current flag without excess"); // [RULE16]

    a_timer_flag: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_motor_timer > dsw_pkg::TIMER_FULL && i_protocol_sel == dsw_pkg::PROTO_NATIVE)
        |=> status_r[dsw_pkg::BIT_TIMER_EXC]) else $error("timer flag missing"); // [RULE17]

    a_read_status: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
        (i_rd_req && (i_rd_addr == dsw_pkg::REG_STATUS_HIGH
                      || i_rd_addr == dsw_pkg::REG_STATUS_LOW))
        |=> (o_rd_valid && !o_rd_err && o_rd_data == $past(status_r)))
        else $error("status read mismatch"); // [RULE20]

endmodule : dsw_status_word

// file: testbench/dsw_bus_master.sv
// Fieldbus master model that polls the drive holding registers.
`timescale 1ns/1ps
module dsw_bus_master (
    // Clock
    input  wire logic        i_ref_clk,
    // Read request
    output logic             o_rd_req,
    output logic [15:0]      o_rd_addr,
    // Read answer
    input  wire logic        i_rd_valid,
    input  wire logic        i_rd_err,
    input  wire logic [15:0] i_rd_data
);
    initial begin
        o_rd_req  = 1'b0;
        o_rd_addr = 16'hffff;
    end

    // The address is inverted once unqualified, so a design that samples it late sees garbage.
    task automatic poll(input logic [15:0] addr, output logic [15:0] data,
                        output logic err, output logic ok);
        int n;
        @(negedge i_ref_clk);
        o_rd_req  <= 1'b1;
        o_rd_addr <= addr;
        @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        o_rd_req  <= 1'b0;
        o_rd_addr <= ~addr;
        n = 0;
        while (i_rd_valid !== 1'b1 && n < 4) begin
            @(negedge i_ref_clk);
            n++;
        end
        ok   = (i_rd_valid === 1'b1);
        data = i_rd_data;
        err  = i_rd_err;
    endtask : poll
endmodule : dsw_bus_master

// file: testbench/test_dsw_status_word.sv
// Self-checking bench for the drive status word block.
`timescale 1ns/1ps
module test_dsw_status_word;
    logic               clk   = 1'b0;
    logic               rst   = 1'b1;
    logic [7:0]         proto = 8'h00;
    logic [11:0]        cond  = 12'h001;
    logic [15:0]        cur   = 16'd100;
    logic [15:0]        lim   = 16'd200;
    logic [15:0]        mtim  = 16'h4000;
    logic [15:0]        dtim  = 16'h4000;
    logic signed [15:0] sref  = 16'sh2000;
    logic signed [15:0] freq  = 16'sd2500;
    logic [15:0]        fmax  = 16'd5000;
    logic [15:0]        flo   = 16'd1000;
    logic [15:0]        fhi   = 16'd4000;
    logic               rd_req;
    logic [15:0]        rd_addr;
    logic               rd_valid;
    logic               rd_err;
    logic [15:0]        rd_data;
    logic [15:0]        word;
    logic signed [15:0] fval;
    int                 err_count  = 0;
    int                 n_compared = 0;
    // Condition mixes: faults together, no control ready, and start while coasting.
    logic [11:0]        combos [6] = '{12'h013, 12'h20d, 12'h00f, 12'h215, 12'h000, 12'h019};

    always #12.5 clk = ~clk;

    dsw_status_word #(.FREQ_W(16)) dut (
        .i_ref_clk(clk), .i_sys_rst(rst), .i_protocol_sel(proto),
        .i_ctrl_ready(cond[0]), .i_tripped(cond[1]), .i_trip_locked(cond[2]),
        .i_coast_cmd(cond[3]), .i_start_cmd(cond[4]), .i_error_no_trip(cond[5]),
        .i_warning(cond[6]), .i_local_off_key(cond[7]), .i_ref_site_local(cond[8]),
        .i_overtemp_halt(cond[9]), .i_dc_low(cond[10]), .i_dc_high(cond[11]),
        .i_motor_current(cur), .i_current_limit(lim), .i_motor_timer(mtim),
        .i_drive_timer(dtim), .i_speed_ref(sref), .i_out_freq(freq), .i_freq_max(fmax),
        .i_freq_low_lim(flo), .i_freq_high_lim(fhi), .i_rd_req(rd_req),
        .i_rd_addr(rd_addr), .o_rd_valid(rd_valid), .o_rd_err(rd_err),
        .o_rd_data(rd_data), .o_drive_status_word(word),
        .o_actual_output_frequency_value(fval)
    );

    dsw_bus_master bfm (
        .i_ref_clk(clk), .o_rd_req(rd_req), .o_rd_addr(rd_addr),
        .i_rd_valid(rd_valid), .i_rd_err(rd_err), .i_rd_data(rd_data)
    );

    // ************************************************************
    // Expectations and checks
    // ************************************************************
    function automatic logic [15:0] exp_word(input logic [15:0] fv);
        logic [15:0] w;
        logic        flt;
        logic [15:0] af;
        flt   = cond[1] | cond[2];
        af    = freq[15] ? 16'(-freq) : 16'(freq);
        w     = 16'h0000;
        w[0]  = cond[0] & ~flt;
        w[1]  = cond[0] & ~flt & cond[3];
        w[2]  = ~cond[3] & ~flt;
        w[3]  = cond[1];
        w[4]  = cond[5];
        w[6]  = cond[2];
        w[7]  = cond[6];
        w[8]  = (fv == 16'(sref));
        w[9]  = ~cond[7] & ~cond[8];
        w[10] = (af > flo) && (af < fhi);
        w[11] = cond[4] & ~cond[3] & ~flt;
        w[12] = cond[9] & ~flt;
        w[13] = cond[10] | cond[11];
        w[14] = cur > lim;
        w[15] = (mtim > dsw_pkg::TIMER_FULL) || (dtim > dsw_pkg::TIMER_FULL);
        return (proto == dsw_pkg::PROTO_NATIVE) ? w : 16'h0000;
    endfunction : exp_word

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [15:0] addr, input logic [15:0] exp, input logic xe);
        logic [15:0] d;
        logic        e;
        logic        ok;
        bfm.poll(addr, d, e, ok);
        chk({15'h0000, ok}, 16'h0001);
        chk({15'h0000, e}, {15'h0000, xe});
        chk(d, exp);
    endtask : rd_chk

    // Waits past the longest output lag, then compares direct views and all four registers.
    task automatic check_all();
        logic [15:0] fv;
        logic [15:0] w;
        repeat (3) @(negedge clk);
        fv = 16'(int'(freq) * int'(dsw_pkg::SCALE_FULL) / int'(fmax));
        w  = exp_word(fv);
        chk(word, w);
        chk(fval, fv);
        rd_chk(dsw_pkg::REG_STATUS_HIGH, w, 1'b0);
        rd_chk(dsw_pkg::REG_STATUS_LOW, w, 1'b0);
        rd_chk(dsw_pkg::REG_VALUE_HIGH, fv, 1'b0);
        rd_chk(dsw_pkg::REG_VALUE_LOW, fv, 1'b0);
    endtask : check_all

    task automatic conclude();
        if (err_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    initial begin
        #1000000;
        err_count++;
        conclude();
    end

    initial begin
        repeat (5) @(negedge clk);
        chk(word, dsw_pkg::STATUS_RESET);
        rst = 1'b0;
        check_all();
        for (int i = 1; i < 12; i++) begin
            cond = 12'h001 | (12'h001 << i);
            check_all();
        end
        for (int i = 0; i < 6; i++) begin
            cond = combos[i];
            check_all();
        end
        cond = 12'h001;
        cur = 16'd200;
        check_all();
        cur = 16'd201;
        check_all();
        mtim = 16'h4001;
        check_all();
        mtim = 16'h4000;
        dtim = 16'h4001;
        check_all();
        freq = 16'sd1000;
        check_all();
        freq = 16'sd4000;
        check_all();
        freq = -16'sd2500;
        sref = -16'sh2000;
        check_all();
        freq = 16'sd5000;
        sref = 16'sh4000;
        check_all();
        proto = 8'h01;
        check_all();
        proto = 8'h00;
        rd_chk(16'hc419, dsw_pkg::READ_MISS_VALUE, 1'b1);
        rd_chk(16'h0b60, dsw_pkg::READ_MISS_VALUE, 1'b1);
        rst = 1'b1;
        @(negedge clk);
        chk(word, dsw_pkg::STATUS_RESET);
        rst = 1'b0;
        check_all();
        conclude();
    end
endmodule : test_dsw_status_word
